/* File: core/lcdc_regs.sv */
/*
 * LCD driver control registers, display memory and segment/backplane drive.
 * Assumes a one-cycle strobe register port and an analog generator that
 * takes the enable and contrast code straight from this block.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_defines.svh"


module lcdc_regs #(
    parameter int unsigned    COM_CYCLES = `LCDC_COM_CYCLES,
    parameter int unsigned    SEGS       = `LCDC_SEGS,
    parameter bit             EXT_SUPPLY = 1'b0,
    parameter logic [SEGS-1:0] DC_MASK   = '0
) (
    input  wire logic            clk,                    // 200 MHz clock
    input  wire logic            rst_b,                  // async reset, active low
    input  wire logic [15:0]     addr,                   // register address
    input  wire logic [3:0]      wdata,                  // write nibble
    input  wire logic            wr,                     // write strobe
    input  wire logic            rd,                     // read strobe
    output logic      [3:0]      rdata,                  // read nibble, next cycle
    output logic                 drive_power_on,         // generator enable
    output logic      [3:0]      first_drive_level_code, // contrast to generator
    output logic      [7:0]      backplane_lines,        // active common, one-hot
    output logic      [SEGS-1:0] dot_drive_pin           // per segment: on waveform
);

    if (COM_CYCLES < 2 || SEGS < 1 || SEGS > `LCDC_DM_WORDS / 2) begin : g_chk
        $error("lcdc_regs: unsupported parameter values");
    end

    function automatic logic [3:0] com_count_of(input logic stat,
                                               input logic [1:0] duty);
        if (stat) begin
            return 4'h1;
        end
        case (lcdc_pkg::lcdc_duty_t'(duty))
            lcdc_pkg::LCDC_DUTY_4: return 4'h4;
            lcdc_pkg::LCDC_DUTY_5: return 4'h5;
            default:               return 4'h8;
        endcase
    endfunction

    function automatic logic dm_hit(input logic [15:0] a);
        return (a >= `LCDC_DM_BASE) &&
               ((a - `LCDC_DM_BASE) < 16'(`LCDC_DM_WORDS));
    endfunction

    // software-visible registers
    logic [3:0] drive_q;
    logic       fon_q;
    logic       foff_q;
    logic [3:0] contrast_q;

    // copies in force for the current frame
    logic       pwr_a_q;
    logic       stat_a_q;
    logic [1:0] duty_a_q;
    logic       fon_a_q;
    logic       foff_a_q;

    logic       eff_pwr;
    logic       eff_stat;
    logic [1:0] eff_duty;
    logic       eff_fon;
    logic       eff_foff;

    logic [3:0]      rdata_q;
    logic [3:0]      rdata_d;
    logic            gen_en_q;
    logic [3:0]      code_q;
    logic [7:0]      com_q;
    logic [SEGS-1:0] dot_q;
    logic [SEGS-1:0] dot_d;

    logic [2:0]      com_idx;
    logic            com_start;
    logic            frame_start;
    logic [3:0]      com_count;
    logic [3:0]      dm_rd;
    logic [7:0]      dm_idx;
    logic            dm_wr;
    logic [SEGS-1:0] row;
    logic [SEGS-1:0] dc_level;

    assign dm_idx = 8'(addr - `LCDC_DM_BASE);
    assign dm_wr  = wr && dm_hit(addr);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            drive_q <= `LCDC_DRIVE_RST;
        end else if (wr && addr == `LCDC_OFS_DRIVE) begin
            drive_q <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fon_q  <= `LCDC_FON_RST;
            foff_q <= `LCDC_FOFF_RST;
        end else if (wr && addr == `LCDC_OFS_FORCE) begin
            // bits 0 and 3 have no storage, so their writes vanish
            fon_q  <= wdata[`LCDC_BIT_FON];
            foff_q <= wdata[`LCDC_BIT_FOFF];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            contrast_q <= `LCDC_CONTRAST_RST;
        end else if (wr && addr == `LCDC_OFS_CONTRAST) begin
            contrast_q <= wdata;
        end
    end

    always_comb begin
        rdata_d = 4'h0;
        case (addr)
            `LCDC_OFS_DRIVE:    rdata_d = drive_q;
            `LCDC_OFS_FORCE:    rdata_d = {1'b0, foff_q, fon_q, 1'b0};
            `LCDC_OFS_CONTRAST: rdata_d = contrast_q;
            default: begin
                if (dm_hit(addr)) begin
                    rdata_d = dm_rd;
                end
            end
        endcase
    end

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 4'h0;
        end else begin
            rdata_q <= rd ? rdata_d : 4'h0;
        end
    end

    // a frame boundary picks up the live registers in the same edge
    always_comb begin
        eff_pwr  = frame_start ? drive_q[`LCDC_BIT_PWR] : pwr_a_q;
        eff_stat = frame_start ? drive_q[`LCDC_BIT_STATIC] : stat_a_q;
        eff_duty = frame_start ? drive_q[`LCDC_BIT_DUTY_HI:`LCDC_BIT_DUTY_LO] : duty_a_q;
        eff_fon  = frame_start ? fon_q : fon_a_q;
        eff_foff = frame_start ? foff_q : foff_a_q;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwr_a_q  <= 1'b0;
            stat_a_q <= 1'b0;
            duty_a_q <= 2'h0;
            fon_a_q  <= `LCDC_FON_RST;
            foff_a_q <= `LCDC_FOFF_RST;
        end else if (frame_start) begin
            pwr_a_q  <= eff_pwr;
            stat_a_q <= eff_stat;
            duty_a_q <= eff_duty;
            fon_a_q  <= eff_fon;
            foff_a_q <= eff_foff;
        end
    end

    // scan length comes from settings in force, so a frame never changes length midway
    assign com_count = com_count_of(stat_a_q, duty_a_q);

    lcdc_scan #(
        .COM_CYCLES (COM_CYCLES)
    ) u_scan (
        .clk         (clk),
        .rst_b       (rst_b),
        .com_count   (com_count),
        .com_idx     (com_idx),
        .com_start   (com_start),
        .frame_start (frame_start)
    );

    lcdc_dmem #(
        .WORDS (`LCDC_DM_WORDS),
        .SEGS  (SEGS)
    ) u_dmem (
        .clk      (clk),
        .wr_en    (dm_wr),
        .wr_idx   (dm_idx),
        .wr_data  (wdata),
        .rd_idx   (dm_idx),
        .rd_data  (dm_rd),
        .com_idx  (com_idx),
        .row      (row),
        .dc_level (dc_level)
    );

    for (genvar i = 0; i < SEGS; i++) begin : g_dot
        // force bits act only on the pin, memory is never rewritten
        assign dot_d[i] = DC_MASK[i] ? dc_level[i]
                        : eff_pwr & (eff_fon | (~eff_foff & row[i]));
    end

    // pins move only at a common boundary, never inside a period
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            com_q <= 8'h00;
            dot_q <= '0;
        end else if (com_start) begin
            com_q <= eff_pwr ? (8'h01 << com_idx) : 8'h00;
            dot_q <= dot_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gen_en_q <= 1'b0;
            code_q   <= 4'h0;
        end else if (frame_start) begin
            gen_en_q <= drive_q[`LCDC_BIT_PWR];
            // external supply: the code is frozen at its lightest value
            code_q   <= EXT_SUPPLY ? 4'h0 : contrast_q;
        end
    end

    assign rdata                  = rdata_q;
    assign drive_power_on         = gen_en_q;
    assign first_drive_level_code = code_q;
    assign backplane_lines        = com_q;
    assign dot_drive_pin          = dot_q;

    a_contrast_apply: assert property (
        @(posedge clk) disable iff (!rst_b)
        (frame_start && !EXT_SUPPLY) |=> first_drive_level_code == $past(contrast_q))
        else $error("contrast code not applied at frame start");

    a_reset_values: assert property (
        @(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> (contrast_q == 4'h0 && foff_q && !fon_q && drive_q == 4'h0))
        else $error("wrong control state after reset");

    a_ext_contrast: assert property (
        @(posedge clk) disable iff (!rst_b)
        EXT_SUPPLY |-> first_drive_level_code == 4'h0)
        else $error("contrast code reached generator with external supply");

    a_power_readback: assert property (
        @(posedge clk) disable iff (!rst_b)
        (wr && addr == `LCDC_OFS_DRIVE) ##1 (rd && addr == `LCDC_OFS_DRIVE && !wr)
        |=> rdata == $past(wdata, 2))
        else $error("drive control did not read back as written");

    a_power_ground: assert property (
        @(posedge clk) disable iff (!rst_b)
        !pwr_a_q && !frame_start |-> backplane_lines == 8'h00 &&
                                     (dot_drive_pin & ~DC_MASK) == '0)
        else $error("drive active while power is off");

    a_dc_pins: assert property (
        @(posedge clk) disable iff (!rst_b)
        // memory starts undefined, so a dc pin may carry x until software fills it
        com_start |=> (dot_drive_pin & DC_MASK) === ($past(dc_level) & DC_MASK))
        else $error("dc pin not following memory");

    a_duty_span: assert property (
        @(posedge clk) disable iff (!rst_b)
        com_start |=> backplane_lines == 8'h00 ||
                      backplane_lines < (9'h001 << $past(com_count)))
        else $error("backplane beyond selected duty");

    a_force_on: assert property (
        @(posedge clk) disable iff (!rst_b)
        (com_start && eff_pwr && eff_fon) |=> (dot_drive_pin | DC_MASK) == '1)
        else $error("force-on did not light every dot");

    a_force_off: assert property (
        @(posedge clk) disable iff (!rst_b)
        (com_start && eff_pwr && !eff_fon && eff_foff) |=>
            (dot_drive_pin & ~DC_MASK) == '0)
        else $error("force-off did not blank every dot");

    a_unused_zero: assert property (
        @(posedge clk) disable iff (!rst_b)
        (rd && addr == `LCDC_OFS_FORCE) |=> rdata[3] == 1'b0 && rdata[0] == 1'b0)
        else $error("unused force bits read non-zero");

    a_dm_readback: assert property (
        @(posedge clk) disable iff (!rst_b)
        (wr && dm_hit(addr)) ##1 (rd && !wr && addr == $past(addr)) |=>
            rdata == $past(wdata, 2))
        else $error("display memory did not read back");

    a_hold_period: assert property (
        @(posedge clk) disable iff (!rst_b)
        !com_start |=> $stable(dot_drive_pin) && $stable(backplane_lines))
        else $error("drive pins changed inside a common period");

    a_gen_follow: assert property (
        @(posedge clk) disable iff (!rst_b)
        frame_start |=> drive_power_on == $past(drive_q[`LCDC_BIT_PWR]))
        else $error("generator enable not taken at frame start");

    a_force_readback: assert property (
        @(posedge clk) disable iff (!rst_b)
        (wr && addr == `LCDC_OFS_FORCE) ##1 (rd && addr == `LCDC_OFS_FORCE && !wr)
        |=> rdata == ($past(wdata, 2) & 4'h6))
        else $error("force bits did not read back as written");

    a_contrast_readback: assert property (
        @(posedge clk) disable iff (!rst_b)
        (wr && addr == `LCDC_OFS_CONTRAST) ##1 (rd && addr == `LCDC_OFS_CONTRAST && !wr)
        |=> rdata == $past(wdata, 2))
        else $error("contrast code did not read back as written");

    a_static_one: assert property (
        @(posedge clk) disable iff (!rst_b)
        (pwr_a_q && stat_a_q && !frame_start) |-> backplane_lines == 8'h01)
        else $error("static drive used a common other than 0");

    a_five_commons: assert property (
        @(posedge clk) disable iff (!rst_b)
        (com_start && pwr_a_q && !stat_a_q && duty_a_q == 2'h1 && com_idx == 3'h4) |=>
            backplane_lines == 8'h10)
        else $error("fifth common missing at 1/5 duty");

    a_eight_commons: assert property (
        @(posedge clk) disable iff (!rst_b)
        (com_start && pwr_a_q && !stat_a_q && duty_a_q[1] && com_idx == 3'h7) |=>
            backplane_lines == 8'h80)
        else $error("eighth common missing at 1/8 duty");

endmodule

`default_nettype wire

/* File: core/lcdc_defines.svh */
/*
 * Offsets, field positions, reset values and timing counts of the LCD
 * driver control block. Assumes inclusion by bare name from core/.
 */
`ifndef LCDC_DEFINES_SVH
`define LCDC_DEFINES_SVH

`define LCDC_OFS_DRIVE          16'hFF60
`define LCDC_OFS_FORCE          16'hFF61
`define LCDC_OFS_CONTRAST       16'hFF62
`define LCDC_DM_BASE            16'hF000
`define LCDC_DM_WORDS           160
`define LCDC_SEGS               56

`define LCDC_BIT_PWR            0
`define LCDC_BIT_STATIC         1
`define LCDC_BIT_DUTY_LO        2
`define LCDC_BIT_DUTY_HI        3
`define LCDC_BIT_FON            1
`define LCDC_BIT_FOFF           2

`define LCDC_DRIVE_RST          4'h0
`define LCDC_FON_RST            1'b0
`define LCDC_FOFF_RST           1'b1
`define LCDC_CONTRAST_RST       4'h0

`define LCDC_CLK_PERIOD_PS      5000
`define LCDC_COM_PERIOD_NS      64000
`define LCDC_COM_CYCLES         ((`LCDC_COM_PERIOD_NS * 1000) / `LCDC_CLK_PERIOD_PS)

`endif

/* File: core/lcdc_pkg.sv */
/*
 * Types of the LCD driver control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package lcdc_pkg;

    typedef enum logic [1:0] {
        LCDC_DUTY_4 = 2'h0,
        LCDC_DUTY_5 = 2'h1,
        LCDC_DUTY_8 = 2'h2
    } lcdc_duty_t;

    typedef enum logic [1:0] {
        LCDC_SC_HOLD = 2'h0,
        LCDC_SC_RUN  = 2'h1,
        LCDC_SC_WRAP = 2'h3
    } lcdc_scan_t;

endpackage

`default_nettype wire

/* File: core/lcdc_scan.sv */
/*
 * Display scan timer: walks the active commons, one common period each.
 * Assumes com_count is stable across a frame and lies in 1..8.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_defines.svh"

module lcdc_scan #(
    parameter int unsigned COM_CYCLES = `LCDC_COM_CYCLES
) (
    input  wire logic       clk,         // system clock
    input  wire logic       rst_b,       // async reset, active low
    input  wire logic [3:0] com_count,   // commons in use this frame
    output logic      [2:0] com_idx,     // common now being driven
    output logic            com_start,   // pulse: new common period
    output logic            frame_start  // pulse: common 0 of a new frame
);

    localparam int unsigned CW = $clog2(COM_CYCLES);

    if (COM_CYCLES < 2) begin : g_chk
        $error("lcdc_scan: COM_CYCLES must be at least 2");
    end

    lcdc_pkg::lcdc_scan_t state_q;
    logic [CW-1:0]        cnt_q;
    logic [2:0]           idx_q;
    logic                 adv_q;
    logic                 last_cnt;
    logic                 last_com;

    assign last_cnt    = (cnt_q == CW'(COM_CYCLES - 1));
    assign last_com    = ({1'b0, idx_q} == (com_count - 4'h1));
    assign com_idx     = idx_q;
    assign frame_start = (state_q == lcdc_pkg::LCDC_SC_WRAP);
    assign com_start   = frame_start | adv_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= lcdc_pkg::LCDC_SC_HOLD;
            cnt_q   <= '0;
            idx_q   <= 3'h0;
            adv_q   <= 1'b0;
        end else begin
            adv_q <= 1'b0;
            case (state_q)
                lcdc_pkg::LCDC_SC_HOLD: begin
                    state_q <= lcdc_pkg::LCDC_SC_WRAP;
                end
                lcdc_pkg::LCDC_SC_WRAP: begin
                    cnt_q   <= '0;
                    state_q <= lcdc_pkg::LCDC_SC_RUN;
                end
                lcdc_pkg::LCDC_SC_RUN: begin
                    if (last_cnt) begin
                        cnt_q <= '0;
                        if (last_com || idx_q == 3'h7) begin
                            idx_q   <= 3'h0;
                            state_q <= lcdc_pkg::LCDC_SC_WRAP;
                        end else begin
                            idx_q <= idx_q + 3'h1;
                            adv_q <= 1'b1;
                        end
                    end else begin
                        cnt_q <= cnt_q + CW'(1);
                    end
                end
                default: begin
                    state_q <= lcdc_pkg::LCDC_SC_HOLD;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: core/lcdc_dmem.sv */
/*
 * Display memory: nibble words, one cpu port, a wide scan read of one row.
 * Assumes two words per segment, bit = common[1:0], word = common[2].
 */
`timescale 1ns/1ps
`default_nettype none

module lcdc_dmem #(
    parameter int unsigned WORDS = 160,
    parameter int unsigned SEGS  = 56
) (
    input  wire logic            clk,       // system clock
    input  wire logic            wr_en,     // cpu write
    input  wire logic [7:0]      wr_idx,    // cpu write word
    input  wire logic [3:0]      wr_data,   // cpu write nibble
    input  wire logic [7:0]      rd_idx,    // cpu read word
    output logic      [3:0]      rd_data,   // cpu read nibble
    input  wire logic [2:0]      com_idx,   // common being scanned
    output logic      [SEGS-1:0] row,       // dot bits of that common
    output logic      [SEGS-1:0] dc_level   // level for dc-output pins
);

    if (2 * SEGS > WORDS || WORDS > 256) begin : g_chk
        $error("lcdc_dmem: memory too small for segment count");
    end

    // no reset: content is undefined until software fills it
    logic [3:0] mem [WORDS];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    assign rd_data = mem[rd_idx];

    for (genvar s = 0; s < SEGS; s++) begin : g_seg
        logic [3:0] wrow;
        assign wrow        = mem[2 * s + int'(com_idx[2])];
        assign row[s]      = wrow[com_idx[1:0]];
        assign dc_level[s] = mem[2 * s][0];
    end

endmodule

`default_nettype wire

/* File: sim/lcdc_panel.sv */
/*
 * LCD glass model seen from the common and segment lines.
 * Assumes the block drives at most one common at a time.
 */
`timescale 1ns/1ps
`default_nettype none

module lcdc_panel (
    input  wire logic        clk,             // system clock
    input  wire logic        rst_b,           // async reset, active low
    input  wire logic [7:0]  backplane_lines, // common drive
    input  wire logic [55:0] dot_drive_pin,   // segment drive
    output logic      [2:0]  active_com,      // common now lit
    output logic             new_com,         // a new common just began
    output logic             one_hot_ok       // no two commons at once
);
    logic [7:0] prev_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) prev_q <= 8'h00;
        else prev_q <= backplane_lines;
    end

    // glass is passive; it only reports which common it sees
    assign new_com    = (backplane_lines != prev_q) && (backplane_lines != 8'h00);
    assign one_hot_ok = $onehot0(backplane_lines);

    always_comb begin
        active_com = 3'h0;
        for (int i = 0; i < 8; i++) if (backplane_lines[i]) active_com = i[2:0];
    end
endmodule

`default_nettype wire

/* File: sim/testbench.sv */
/*
 * Self-checking bench for the LCD driver control block.
 * Assumes the glass model and a short common period in simulation.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int COM = 4;
    logic        clk, rst_b, wr, rd, pwr, new_com, oh_ok;
    logic [15:0] addr;
    logic [3:0]  wdata, rdata, code, ext_code, r, prev;
    logic [7:0]  bp;
    logic [2:0]  acom;
    logic [55:0] dots, ext_dots;
    logic [31:0] rnd;
    logic [3:0]  mem [0:159];
    logic [3:0]  dv [4] = '{4'h1, 4'h5, 4'h9, 4'hD};
    int          nv [4] = '{4, 5, 8, 8};
    int          errors, total_checks, i, k;
    integer      seed;

    lcdc_regs #(.COM_CYCLES(COM)) dut (.clk(clk), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .drive_power_on(pwr),
        .first_drive_level_code(code), .backplane_lines(bp), .dot_drive_pin(dots));
    // external supply and one dc pin, sharing the same bus traffic
    lcdc_regs #(.COM_CYCLES(COM), .EXT_SUPPLY(1'b1), .DC_MASK(56'h1)) dut_ext (
        .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(), .drive_power_on(), .first_drive_level_code(ext_code),
        .backplane_lines(), .dot_drive_pin(ext_dots));
    lcdc_panel glass (.clk(clk), .rst_b(rst_b), .backplane_lines(bp),
        .dot_drive_pin(dots), .active_com(acom), .new_com(new_com), .one_hot_ok(oh_ok));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [3:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [15:0] a, output logic [3:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // write then read the same address with no idle cycle between the strobes
    task automatic wr_rd(input logic [15:0] a, input logic [3:0] d, output logic [3:0] q);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        q = rdata;
    endtask

    function automatic logic [55:0] exp_dots(input int com, input logic fon, input logic foff);
        logic [55:0] v;
        for (int s = 0; s < 56; s++) v[s] = mem[2*s + com/4][com%4];
        if (fon) v = '1;
        else if (foff) v = '0;
        return v;
    endfunction

    task automatic sync_frame;
        int n;
        for (n = 0; n < 100; n++) begin
            @(negedge clk);
            if (new_com && bp === 8'h01) break;
        end
        check("frame_sync", n < 100, 1'b1);
    endtask

    task automatic wait_com;
        int n;
        for (n = 0; n < 40; n++) begin
            @(negedge clk);
            if (new_com) break;
        end
        check("common_period", n <= COM, 1'b1);
    endtask

    task automatic frame_check(input int n, input logic fon, input logic foff);
        int c;
        sync_frame();
        for (c = 0; c < n; c++) begin
            if (c > 0) wait_com();
            check("backplane", bp, 8'h01 << c);
            check("common", acom, c[2:0]);
            check("one_hot", oh_ok, 1'b1);
            check("dots", dots, exp_dots(c, fon, foff));
        end
        if (n > 1) begin
            wait_com();
            check("wrap", bp, 8'h01);
        end else begin
            repeat (3*COM) @(negedge clk);
            check("static_common", bp, 8'h01);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        tally_and_finish();
    end

    initial begin
        seed = 32'hA4EB;
        rst_b = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 16'h0000;
        wdata = 4'h0;
        errors = 0;
        total_checks = 0;
        repeat (5) @(negedge clk);
        check("reset_power", pwr, 1'b0);
        check("reset_code", code, 4'h0);
        check("reset_lines", {bp, dots}, 64'h0);
        @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(16'hFF60, r);
        check("drive_reset", r, 4'h0);
        rd_reg(16'hFF61, r);
        check("force_reset", r, 4'h4);
        rd_reg(16'hFF62, r);
        check("contrast_reset", r, 4'h0);
        for (i = 0; i < 8; i++) begin
            rnd = $random(seed);
            wr_rd(16'hFF60, rnd[3:0], r);
            check("drive_rw", r, rnd[3:0]);
            wr_rd(16'hFF61, rnd[7:4], r);
            check("force_rw", r, rnd[7:4] & 4'h6);
            wr_reg(16'hFF63, rnd[11:8]);
            rd_reg(16'hFF63, r);
            check("unmapped", r, 4'h0);
        end
        // memory and contrast are set up and force-off is cleared before display; power is set with each duty
        for (i = 0; i < 160; i++) begin
            rnd = $random(seed);
            mem[i] = rnd[3:0];
            wr_rd(16'hF000 + 16'(i), mem[i], r);
            check("dmem_wr_rd", r, mem[i]);
        end
        for (i = 0; i < 160; i++) begin
            rd_reg(16'hF000 + 16'(i), r);
            check("dmem_rw", r, mem[i]);
        end
        rd_reg(16'hF0A0, r);
        check("dmem_end", r, 4'h0);
        wr_reg(16'hFF61, 4'h0);
        wr_reg(16'hFF62, 4'h3);
        // the bench does not model the 100 ms settle time
        for (k = 0; k < 4; k++) begin
            wr_reg(16'hFF60, dv[k]);
            frame_check(nv[k], 1'b0, 1'b0);
        end
        wr_reg(16'hFF61, 4'h2);
        frame_check(8, 1'b1, 1'b0);
        wr_reg(16'hFF61, 4'h6);
        frame_check(8, 1'b1, 1'b1);
        wr_reg(16'hFF61, 4'h4);
        frame_check(8, 1'b0, 1'b1);
        wr_reg(16'hFF61, 4'h0);
        frame_check(8, 1'b0, 1'b0);
        for (i = 0; i < 160; i += 37) begin
            rd_reg(16'hF000 + 16'(i), r);
            check("dmem_kept", r, mem[i]);
        end
        // codes of 7 and up assume the regulator is not in halving mode
        prev = 4'h3;
        for (k = 0; k < 16; k++) begin
            sync_frame();
            wr_rd(16'hFF62, k[3:0], r);
            check("contrast_rw", r, k[3:0]);
            @(negedge clk);
            check("contrast_held", code, prev);
            check("ext_contrast", ext_code, 4'h0);
            sync_frame();
            repeat (2) @(negedge clk);
            check("contrast_code", code, k[3:0]);
            prev = k[3:0];
        end
        sync_frame();
        wr_reg(16'hFF60, 4'h0);
        @(negedge clk);
        check("power_held", pwr, 1'b1);
        repeat (80) @(negedge clk);
        check("power_off", pwr, 1'b0);
        check("power_off_lines", {bp, dots}, 64'h0);
        check("dc_pin", ext_dots[0], mem[0][0]);
        wr_reg(16'hFF60, 4'h3);
        frame_check(1, 1'b0, 1'b0);
        tally_and_finish();
    end
endmodule

`default_nettype wire
